// [dv/periodic_interrupt_timer_regs_test.sv]
`timescale 1ns/1ps
`default_nettype none
module periodic_interrupt_timer_regs_test;
    import pit_pkg::*;
    logic        core_clk     = 1'b0;
    logic        rst          = 1'b1;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [11:0] paddr        = 12'h000;
    logic [31:0] pwdata       = 32'h0000_0000;
    logic        break_active = 1'b0;
    logic        stop_mode    = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        err_seen;
    logic [31:0] rd;
    logic [15:0] v1;
    logic [15:0] v2;
    int          fails        = 0;
    int          comparisons  = 0;

    // 10 MHz bus clock
    always #50 core_clk = ~core_clk;

    periodic_interrupt_timer i_periodic_interrupt_timer (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .break_active(break_active),
        .stop_mode(stop_mode), .irq(irq)
    );

    // verdict and end of run
    task automatic print_verdict();
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare a bus value
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // compare a single pin or flag
    task automatic check_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error are taken at the edge with pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            print_verdict();
        end
        err_seen = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check_reg(rd, {24'h000000, e});
    endtask

    // read high then low, which also releases the low-byte latch
    task automatic rcount(output logic [15:0] v);
        apb(1'b0, ADDR_COUNT_HIGH, 32'h0000_0000);
        v[15:8] = rd[7:0];
        apb(1'b0, ADDR_COUNT_LOW, 32'h0000_0000);
        v[7:0] = rd[7:0];
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check_pin(irq, 1'b0);
        rchk(ADDR_STATUS_CONTROL, 8'h20);
        rchk(ADDR_COUNT_HIGH, 8'h00);
        rchk(ADDR_COUNT_LOW, 8'h00);
        rchk(ADDR_MODULO_HIGH, 8'hff);
        rchk(ADDR_MODULO_LOW, 8'hff);
        // unmapped address is refused with zero data
        apb(1'b0, 12'h014, 32'h0000_0000);
        check_pin(err_seen, 1'b1);
        check_reg(rd, 32'h0000_0000);
        wr(ADDR_MODULO_LOW, 8'h5a);
        rchk(ADDR_MODULO_LOW, 8'h5a);
        // high modulo byte alone keeps the flag down while matches pass
        wr(ADDR_STATUS_CONTROL, 8'h30);
        wr(ADDR_MODULO_HIGH, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        repeat (400) @(posedge core_clk);
        rchk(ADDR_STATUS_CONTROL, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h10);
        wr(ADDR_MODULO_LOW, 8'h04);
        repeat (20) @(posedge core_clk);
        rchk(ADDR_STATUS_CONTROL, 8'h80);
        check_pin(irq, 1'b0);
        // modulo zero overflows every tick, so a clearing write is overtaken
        wr(ADDR_MODULO_HIGH, 8'h00);
        wr(ADDR_MODULO_LOW, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'h10);
        rchk(ADDR_STATUS_CONTROL, 8'h80);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        rchk(ADDR_STATUS_CONTROL, 8'h80);
        wr(ADDR_STATUS_CONTROL, 8'h60);
        check_pin(irq, 1'b1);
        wr(ADDR_STATUS_CONTROL, 8'h60);
        rchk(ADDR_STATUS_CONTROL, 8'he0);
        wr(ADDR_STATUS_CONTROL, 8'he0);
        rchk(ADDR_STATUS_CONTROL, 8'he0);
        wr(ADDR_STATUS_CONTROL, 8'h60);
        rchk(ADDR_STATUS_CONTROL, 8'h60);
        check_pin(irq, 1'b0);
        // halt and clear together, clear bit reads back zero
        wr(ADDR_STATUS_CONTROL, 8'h70);
        rchk(ADDR_STATUS_CONTROL, 8'h60);
        rcount(v1);
        check_reg({16'h0000, v1}, 32'h0000_0000);
        wr(ADDR_MODULO_HIGH, 8'hff);
        wr(ADDR_MODULO_LOW, 8'hff);
        // low byte latched by a high read survives counting and further high reads
        wr(ADDR_STATUS_CONTROL, 8'h00);
        repeat (40) @(posedge core_clk);
        wr(ADDR_STATUS_CONTROL, 8'h20);
        rcount(v1);
        apb(1'b0, ADDR_COUNT_HIGH, 32'h0000_0000);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        repeat (300) @(posedge core_clk);
        apb(1'b0, ADDR_COUNT_HIGH, 32'h0000_0000);
        wr(ADDR_STATUS_CONTROL, 8'h20);
        apb(1'b0, ADDR_COUNT_LOW, 32'h0000_0000);
        check_reg(rd, {24'h000000, v1[7:0]});
        // every prescale code over about 515 running cycles, from a clean start
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_STATUS_CONTROL, 8'h30 | 8'(c));
            rchk(ADDR_STATUS_CONTROL, 8'h20 | 8'(c));
            wr(ADDR_STATUS_CONTROL, 8'(c));
            repeat (512) @(posedge core_clk);
            wr(ADDR_STATUS_CONTROL, 8'h20 | 8'(c));
            rcount(v1);
            v2 = 16'(516 >> (c == 7 ? 6 : c));
            check_pin((v1 + 16'd3 >= v2) && (v1 <= v2 + 16'd3), 1'b1);
        end
        // break and stop freeze the counter, release lets it run on
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_STATUS_CONTROL, 8'h00);
            break_active <= (m == 0);
            stop_mode <= (m == 1);
            @(posedge core_clk);
            rcount(v1);
            repeat (50) @(posedge core_clk);
            rcount(v2);
            check_reg({16'h0000, v2}, {16'h0000, v1});
            break_active <= 1'b0;
            stop_mode <= 1'b0;
            repeat (50) @(posedge core_clk);
            rcount(v2);
            check_pin(v2 !== v1, 1'b1);
        end
        print_verdict();
    end
endmodule
`default_nettype wire

// [verilog/periodic_interrupt_timer.sv]
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module periodic_interrupt_timer (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        break_active,
    input  wire logic        stop_mode,
    output logic             irq
);
    import pit_pkg::*;

    typedef struct packed {
        logic        flag;
        logic        flag_armed;
        logic        irq_en;
        logic        halt;
        logic [2:0]  ps;
        logic [5:0]  prescale;
        logic [15:0] count;
        logic [7:0]  low_latch;
        logic        latched;
        logic [7:0]  mod_hi;
        logic [7:0]  mod_lo;
        logic        mod_inhibit;
        logic        rd_wait;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic       wr;
    logic       rd;
    logic       rd_first;
    logic       mapped;
    logic       tick;
    logic       wrap;
    logic [5:0] tap_mask;
    logic [15:0] modulo;

    // mask of prescaler bits that must all be one for a tick
    function automatic logic [5:0] tap_of(input logic [2:0] code);
        logic [2:0] c;
        c = (code > PS_MAX_CODE) ? PS_MAX_CODE : code;
        case (c)
            3'h0:    tap_of = 6'h00;
            3'h1:    tap_of = 6'h01;
            3'h2:    tap_of = 6'h03;
            3'h3:    tap_of = 6'h07;
            3'h4:    tap_of = 6'h0f;
            3'h5:    tap_of = 6'h1f;
            default: tap_of = 6'h3f;
        endcase
    endfunction

    // apb decode; writes complete at once, reads take one wait state so prdata is a flop
    always_comb begin
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        rd_first = rd && !s_q.rd_wait;
        mapped = (paddr == ADDR_STATUS_CONTROL) || (paddr == ADDR_COUNT_HIGH) ||
                 (paddr == ADDR_COUNT_LOW) || (paddr == ADDR_MODULO_HIGH) ||
                 (paddr == ADDR_MODULO_LOW);
        pready = !rd_first;
        pslverr = psel && penable && pready && !mapped;
        prdata = s_q.rdata;
        modulo = {s_q.mod_hi, s_q.mod_lo};
        tap_mask = tap_of(s_q.ps);
        tick = !s_q.halt && !break_active && !stop_mode &&
               ((s_q.prescale & tap_mask) == tap_mask);
        wrap = tick && (s_q.count == modulo);
        irq = s_q.flag && s_q.irq_en;
    end

    // next-state logic
    always_comb begin
        s_d = s_q;
        s_d.rd_wait = rd_first;
        // prescaler and counter
        if (!s_q.halt && !break_active && !stop_mode) begin
            s_d.prescale = s_q.prescale + 6'h01;
        end
        if (tick) begin
            s_d.count = wrap ? COUNT_ZERO : s_q.count + 16'h0001;
        end
        // reads, with read-side effects applied once in the first access cycle
        if (rd_first) begin
            case (paddr)
                ADDR_STATUS_CONTROL: begin
                    s_d.rdata = {24'h000000, s_q.flag, s_q.irq_en, s_q.halt,
                                 2'b00, s_q.ps};
                    if (s_q.flag) begin
                        s_d.flag_armed = 1'b1;
                    end
                end
                ADDR_COUNT_HIGH: begin
                    s_d.rdata = {24'h000000, s_q.count[15:8]};
                    if (!s_q.latched) begin
                        s_d.low_latch = s_q.count[7:0];
                        s_d.latched = 1'b1;
                    end
                end
                ADDR_COUNT_LOW: begin
                    s_d.rdata = {24'h000000,
                                 s_q.latched ? s_q.low_latch : s_q.count[7:0]};
                    s_d.latched = 1'b0;
                end
                ADDR_MODULO_HIGH: s_d.rdata = {24'h000000, s_q.mod_hi};
                ADDR_MODULO_LOW:  s_d.rdata = {24'h000000, s_q.mod_lo};
                default:          s_d.rdata = 32'h0000_0000;
            endcase
        end
        // writes
        if (wr) begin
            case (paddr)
                ADDR_STATUS_CONTROL: begin
                    s_d.irq_en = pwdata[BIT_IRQ_ENABLE];
                    s_d.halt = pwdata[BIT_HALT];
                    s_d.ps = pwdata[PS_LSB +: PS_W];
                    if (!pwdata[BIT_OVERFLOW_FLAG] && s_q.flag_armed) begin
                        s_d.flag = 1'b0;
                    end
                    s_d.flag_armed = 1'b0;
                    if (pwdata[BIT_CLEAR]) begin
                        s_d.count = COUNT_ZERO;
                        s_d.prescale = PRESCALE_ZERO;
                        s_d.latched = 1'b0;
                        s_d.low_latch = 8'h00;
                    end
                end
                ADDR_MODULO_HIGH: begin
                    s_d.mod_hi = pwdata[7:0];
                    s_d.mod_inhibit = 1'b1;
                end
                ADDR_MODULO_LOW: begin
                    s_d.mod_lo = pwdata[7:0];
                    s_d.mod_inhibit = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // an unsuppressed overflow sets the flag and wins over any clear
        if (wrap && !s_q.mod_inhibit) begin
            s_d.flag = 1'b1;
            s_d.flag_armed = 1'b0;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '{flag: 1'b0, flag_armed: 1'b0, irq_en: 1'b0, halt: HALT_RESET,
                     ps: PS_RESET, prescale: PRESCALE_ZERO, count: COUNT_ZERO,
                     low_latch: 8'h00, latched: 1'b0, mod_hi: MODULO_RESET,
                     mod_lo: MODULO_RESET, mod_inhibit: 1'b0, rd_wait: 1'b0,
                     rdata: 32'h0000_0000};
        end else begin
            s_q <= s_d;
        end
    end

    // flag only falls after a set-flag status read followed by a zero write
    property p_flag_clear_needs_arm;
        @(posedge core_clk) disable iff (rst)
        $fell(s_q.flag) |-> $past(s_q.flag_armed) && $past(wr);
    endproperty
    a_flag_clear_needs_arm: assert property (p_flag_clear_needs_arm)
        else $error("overflow flag cleared without read-then-write");

    // an unsuppressed wrap always leaves the flag set
    property p_wrap_sets_flag;
        @(posedge core_clk) disable iff (rst)
        (wrap && !s_q.mod_inhibit) |=> s_q.flag;
    endproperty
    a_wrap_sets_flag: assert property (p_wrap_sets_flag)
        else $error("overflow lost");

    // a wrap returns the counter to zero
    property p_wrap_zero;
        @(posedge core_clk) disable iff (rst)
        (wrap && !(wr && paddr == ADDR_STATUS_CONTROL)) |=> s_q.count == COUNT_ZERO;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero)
        else $error("counter did not restart at zero");

    // halted or in break, the counter does not move
    property p_halt_holds;
        @(posedge core_clk) disable iff (rst)
        (s_q.halt || break_active || stop_mode) && !wr |=> $stable(s_q.count);
    endproperty
    a_halt_holds: assert property (p_halt_holds)
        else $error("counter moved while halted");

    // clear write zeroes counter and prescaler
    property p_clear_zero;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_STATUS_CONTROL && pwdata[BIT_CLEAR] && pwdata[BIT_HALT]
        |=> s_q.count == COUNT_ZERO && s_q.prescale == PRESCALE_ZERO ##1 s_q.count == COUNT_ZERO;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("halt plus clear did not hold counter at zero");

    // status read returns zero in the clear and reserved bits
    property p_clear_reads_zero;
        @(posedge core_clk) disable iff (rst)
        rd && paddr == ADDR_STATUS_CONTROL |=> prdata[BIT_CLEAR:3] == 2'b00;
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero)
        else $error("clear bit read back nonzero");

    // irq follows flag and enable
    property p_irq;
        @(posedge core_clk) disable iff (rst)
        irq == (s_q.flag && s_q.irq_en);
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq does not match flag and enable");

    // while a modulo high write is pending, no wrap sets the flag
    property p_mod_inhibit;
        @(posedge core_clk) disable iff (rst)
        !s_q.flag && s_q.mod_inhibit && !wr |=> !s_q.flag;
    endproperty
    a_mod_inhibit: assert property (p_mod_inhibit)
        else $error("flag set while modulo update pending");

    // divide-by-one counts every cycle when running
    property p_div1;
        @(posedge core_clk) disable iff (rst)
        s_q.ps == 3'h0 && !s_q.halt && !break_active && !stop_mode && !wr && !wrap
        |=> s_q.count == $past(s_q.count) + 16'h0001;
    endproperty
    a_div1: assert property (p_div1)
        else $error("counter did not advance at divide by one");

    // writing one to the flag bit never clears it
    property p_write_one_keeps_flag;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_STATUS_CONTROL && pwdata[BIT_OVERFLOW_FLAG] && s_q.flag |=> s_q.flag;
    endproperty
    a_write_one_keeps_flag: assert property (p_write_one_keeps_flag)
        else $error("flag cleared by a write of one");

    // irq enable takes the written bit
    property p_irq_en_write;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_STATUS_CONTROL |=> s_q.irq_en == $past(pwdata[BIT_IRQ_ENABLE]);
    endproperty
    a_irq_en_write: assert property (p_irq_en_write)
        else $error("irq enable not written");

    // halt takes the written bit
    property p_halt_write;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_STATUS_CONTROL |=> s_q.halt == $past(pwdata[BIT_HALT]);
    endproperty
    a_halt_write: assert property (p_halt_write)
        else $error("halt bit not written");

    // prescale select takes the written field
    property p_ps_write;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_STATUS_CONTROL |=> s_q.ps == $past(pwdata[2:0]);
    endproperty
    a_ps_write: assert property (p_ps_write)
        else $error("prescale select not written");

    // a latched low byte holds until the low byte is read or the counter is cleared
    property p_latch_holds;
        @(posedge core_clk) disable iff (rst)
        s_q.latched && !(rd && paddr == ADDR_COUNT_LOW) && !(wr && paddr == ADDR_STATUS_CONTROL)
        |=> s_q.latched && $stable(s_q.low_latch);
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("low byte latch lost");

    // a low byte read releases the latch
    property p_low_read_releases;
        @(posedge core_clk) disable iff (rst)
        rd && paddr == ADDR_COUNT_LOW |=> !s_q.latched;
    endproperty
    a_low_read_releases: assert property (p_low_read_releases)
        else $error("low byte latch not released");

    // a modulo high write sets the suppression
    property p_mod_hi_inhibits;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_MODULO_HIGH |=> s_q.mod_inhibit;
    endproperty
    a_mod_hi_inhibits: assert property (p_mod_hi_inhibits)
        else $error("modulo high write did not suppress the flag");

    // a modulo low write ends the suppression
    property p_mod_lo_releases;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_MODULO_LOW |=> !s_q.mod_inhibit;
    endproperty
    a_mod_lo_releases: assert property (p_mod_lo_releases)
        else $error("modulo low write did not end suppression");

    // modulo high takes the written byte
    property p_mod_write;
        @(posedge core_clk) disable iff (rst)
        wr && paddr == ADDR_MODULO_HIGH |=> s_q.mod_hi == $past(pwdata[7:0]);
    endproperty
    a_mod_write: assert property (p_mod_write)
        else $error("modulo high not written");

    // every tick without a wrap or a clear write advances the counter by one
    property p_tick_advance;
        @(posedge core_clk) disable iff (rst)
        tick && !wrap && !wr |=> s_q.count == $past(s_q.count) + 16'h0001;
    endproperty
    a_tick_advance: assert property (p_tick_advance)
        else $error("counter did not advance on a tick");

    // break or stop also freezes the prescaler
    property p_freeze_prescale;
        @(posedge core_clk) disable iff (rst)
        (break_active || stop_mode) && !wr |=> $stable(s_q.prescale);
    endproperty
    a_freeze_prescale: assert property (p_freeze_prescale)
        else $error("prescaler moved in break or stop");
endmodule
`default_nettype wire

// [verilog/pit_pkg.sv]
package pit_pkg;
    // register offsets (byte addresses, one word each)
    localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_COUNT_HIGH     = 12'h004;
    localparam logic [11:0] ADDR_COUNT_LOW      = 12'h008;
    localparam logic [11:0] ADDR_MODULO_HIGH    = 12'h00c;
    localparam logic [11:0] ADDR_MODULO_LOW     = 12'h010;

    // status/control field positions
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int BIT_IRQ_ENABLE    = 6;
    localparam int BIT_HALT          = 5;
    localparam int BIT_CLEAR         = 4;
    localparam int PS_LSB            = 0;
    localparam int PS_W              = 3;

    // reset values, and the highest decoded prescale code
    localparam logic       HALT_RESET    = 1'b1;
    localparam logic [2:0] PS_RESET      = 3'h0;
    localparam logic [7:0] MODULO_RESET  = 8'hff;
    localparam logic [5:0] PRESCALE_ZERO = 6'h00;
    localparam logic [15:0] COUNT_ZERO   = 16'h0000;
    localparam logic [2:0] PS_MAX_CODE   = 3'h6;
endpackage
